/* File: core/dma_service_core.sv */
/*
 Four-channel DMA service core: bus hold handshake, acknowledges, upper address
 latch control, memory strobes, channel registers and programming access.
 Assumes programming strobes are one-cycle pulses synchronous to ref_clk and
 that the surrounding logic resolves three-state pins from the enables.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1 - Hold request when unmasked channel requests
// R2 - Four acknowledges, programmable polarity
// R3 - Acknowledges active low after reset
// R4 - Upper address enable active high
// R5 - System may gate drivers with enable
// R6 - Upper address strobe pulses high
// R7 - Memory read strobe active low, three-state
// R8 - Memory write strobe active low, three-state
// R9 - Per channel base address and count
// R10 - Per channel current address and count
// R11 - Shared temporary address and count
// R12 - Priority encoder picks single winner
// R13 - Decode commands and per channel mode
// R14 - All timing from single clock
// R15 - Status, command, temp, mode, mask, request
// R16 - Memory strobes float when not owning bus
// R17 - Low address lines input idle, output active
// R18 - Middle address enabled only during service
// R19 - Programming allowed until hold grant arrives
module dma_service_core (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [3:0] channel_request,
    input  wire logic       bus_hold_grant,
    input  wire logic       ready,
    input  wire logic       prog_select,
    input  wire logic       prog_read,
    input  wire logic       prog_write,
    input  wire logic [3:0] low_address_in,
    input  wire logic [7:0] data_in,
    output logic            bus_hold_request,
    output logic [3:0]      channel_acknowledge,
    output logic            upper_address_enable,
    output logic            upper_address_strobe,
    output logic            memory_read_strobe_n,
    output logic            memory_read_oe,
    output logic            memory_write_strobe_n,
    output logic            memory_write_oe,
    output logic [3:0]      low_address_out,
    output logic            low_address_oe,
    output logic [3:0]      middle_address_lines,
    output logic            middle_address_oe,
    output logic [7:0]      data_out,
    output logic            data_oe
);
    dma_pkg::svc_state_t state_reg;
    dma_pkg::svc_state_t state_next;
    dma_pkg::mode_t      mode_reg [4];
    dma_pkg::mode_t      mode_act;
    logic [15:0] base_addr_reg [4];
    logic [15:0] base_count_reg [4];
    logic [15:0] cur_addr_reg [4];
    logic [15:0] cur_count_reg [4];
    logic [15:0] temp_addr_reg;
    logic [15:0] temp_count_reg;
    logic [7:0]  command_reg;
    logic [7:0]  temp_data_reg;
    logic [3:0]  status_tc_reg;
    logic [3:0]  mask_reg;
    logic [3:0]  request_reg;
    logic        byte_ff_reg;
    logic [1:0]  chan_reg;
    logic [1:0]  chan_next;
    logic [1:0]  winner;
    logic [1:0]  prog_chan;
    logic [3:0]  chan_active;
    logic [3:0]  valid;
    logic        any_valid;
    logic        mm_on;
    logic        own;
    logic        drive;
    logic        tc_hit;
    logic        tc_event;
    logic        step_event;
    logic        is_read;
    logic        is_write;
    logic        service_done;
    logic        prog_ok;
    logic        wr_ok;
    logic        rd_ok;
    logic        ack_level;
    logic [15:0] stepped_addr;
    logic [15:0] prog_word;
    logic [7:0]  read_byte;

    // Requests are held off by the disable bit and by each mask bit
    assign chan_active = (channel_request ^ {4{command_reg[dma_pkg::CMD_REQ_LOW]}}) | request_reg;
    assign valid = command_reg[dma_pkg::CMD_DISABLE] ? 4'h0 : (chan_active & ~mask_reg); // R1

    priority_pick u_pick (
        .pending (valid),
        .found   (any_valid),
        .winner  (winner)
    ); // R12

    assign mm_on     = command_reg[dma_pkg::CMD_MEM_TO_MEM];
    assign mode_act  = mode_reg[chan_reg]; // R13
    assign own       = bus_hold_grant && (state_reg inside {dma_pkg::ST_S1, dma_pkg::ST_S2,
                                                            dma_pkg::ST_S3, dma_pkg::ST_S4});
    assign drive     = own && (mode_act.service != dma_pkg::SVC_CASCADE);
    assign is_read   = mm_on ? (chan_reg == 2'h0) : (mode_act.transfer == dma_pkg::XFER_READ);
    assign is_write  = mm_on ? (chan_reg == 2'h1) : (mode_act.transfer == dma_pkg::XFER_WRITE);
    assign tc_hit    = (temp_count_reg == dma_pkg::LAST_COUNT);
    assign step_event = own && (state_reg == dma_pkg::ST_S4);
    assign tc_event  = step_event && tc_hit;
    assign stepped_addr = mode_act.decrement ? temp_addr_reg - dma_pkg::ONE16
                                             : temp_addr_reg + dma_pkg::ONE16;
    assign service_done = mm_on ? (chan_reg == 2'h1 && tc_hit)
                        : (tc_hit || mode_act.service == dma_pkg::SVC_SINGLE
                           || (mode_act.service == dma_pkg::SVC_DEMAND && !chan_active[chan_reg]));
    // Programming stays open in S0 since the grant has not come back yet
    assign prog_ok   = prog_select && !bus_hold_grant; // R19
    assign wr_ok     = prog_ok && prog_write;
    assign rd_ok     = prog_ok && prog_read;
    assign prog_chan = low_address_in[2:1];
    assign ack_level = command_reg[dma_pkg::CMD_ACK_HIGH];
    assign prog_word = low_address_in[0] ? cur_count_reg[prog_chan] : cur_addr_reg[prog_chan];

    always_comb
    begin
        state_next = state_reg;
        chan_next  = chan_reg;
        unique case (state_reg)
            dma_pkg::ST_IDLE:
                if (any_valid)
                    state_next = dma_pkg::ST_S0;
            dma_pkg::ST_S0:
                if (bus_hold_grant)
                begin
                    state_next = dma_pkg::ST_S1;
                    chan_next  = mm_on ? 2'h0 : winner;
                end
                else if (!any_valid)
                    state_next = dma_pkg::ST_IDLE;
            dma_pkg::ST_S1:
                if (mode_act.service != dma_pkg::SVC_CASCADE)
                    state_next = dma_pkg::ST_S2;
                else if (!chan_active[chan_reg])
                    state_next = dma_pkg::ST_IDLE;
            dma_pkg::ST_S2:
                state_next = dma_pkg::ST_S3;
            dma_pkg::ST_S3:
                if (ready || mode_act.transfer == dma_pkg::XFER_VERIFY)
                    state_next = dma_pkg::ST_S4;
            dma_pkg::ST_S4:
            begin
                state_next = service_done ? dma_pkg::ST_IDLE : dma_pkg::ST_S1;
                if (mm_on)
                    chan_next = {1'b0, ~chan_reg[0]};
            end
        endcase
        if (state_reg inside {dma_pkg::ST_S1, dma_pkg::ST_S2, dma_pkg::ST_S3, dma_pkg::ST_S4}
            && !bus_hold_grant)
            state_next = dma_pkg::ST_IDLE;
    end

    // Every step of the service advances on ref_clk alone
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= dma_pkg::ST_IDLE;
            chan_reg  <= 2'h0;
        end
        else
        begin
            state_reg <= state_next; // R14
            chan_reg  <= chan_next;
        end
    end

    // Channel words; programming loads base and current together
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int c = 0; c < dma_pkg::CHANNELS; c++)
            begin
                base_addr_reg[c]  <= 16'h0000;
                base_count_reg[c] <= 16'h0000;
                cur_addr_reg[c]   <= 16'h0000;
                cur_count_reg[c]  <= 16'h0000;
                mode_reg[c]       <= '0;
            end
            temp_addr_reg  <= 16'h0000;
            temp_count_reg <= 16'h0000;
            temp_data_reg  <= 8'h00;
        end
        else
        begin
            if (wr_ok && !low_address_in[3])
            begin
                if (low_address_in[0])
                begin
                    base_count_reg[prog_chan][byte_ff_reg*8 +: 8] <= data_in; // R9
                    cur_count_reg[prog_chan][byte_ff_reg*8 +: 8]  <= data_in; // R10
                end
                else
                begin
                    base_addr_reg[prog_chan][byte_ff_reg*8 +: 8] <= data_in; // R9
                    cur_addr_reg[prog_chan][byte_ff_reg*8 +: 8]  <= data_in; // R10
                end
            end
            if (wr_ok && low_address_in == dma_pkg::ADR_MODE)
                mode_reg[data_in[1:0]] <= data_in[7:2]; // R13
            if (own && state_reg == dma_pkg::ST_S1)
            begin
                temp_addr_reg  <= cur_addr_reg[chan_reg]; // R11
                temp_count_reg <= cur_count_reg[chan_reg]; // R11
            end
            if (drive && mm_on && chan_reg == 2'h0 && state_reg == dma_pkg::ST_S3)
                temp_data_reg <= data_in; // R15
            if (step_event)
            begin
                if (tc_hit && mode_act.autoinit)
                begin
                    cur_addr_reg[chan_reg]  <= base_addr_reg[chan_reg];
                    cur_count_reg[chan_reg] <= base_count_reg[chan_reg];
                end
                else
                begin
                    cur_addr_reg[chan_reg]  <= stepped_addr; // R10
                    cur_count_reg[chan_reg] <= temp_count_reg - dma_pkg::ONE16; // R10
                end
            end
        end
    end

    // Command, mask, request, status and byte pointer; a count end beats a status read
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            command_reg   <= dma_pkg::COMMAND_RESET; // R3
            mask_reg      <= dma_pkg::MASK_RESET;
            request_reg   <= 4'h0;
            status_tc_reg <= 4'h0;
            byte_ff_reg   <= 1'b0;
        end
        else if (wr_ok && low_address_in == dma_pkg::ADR_MASTER_CLEAR)
        begin
            command_reg   <= dma_pkg::COMMAND_RESET; // R13
            mask_reg      <= dma_pkg::MASK_RESET;
            request_reg   <= 4'h0;
            status_tc_reg <= 4'h0;
            byte_ff_reg   <= 1'b0;
        end
        else
        begin
            if ((wr_ok || rd_ok) && !low_address_in[3])
                byte_ff_reg <= ~byte_ff_reg;
            if (wr_ok && low_address_in == dma_pkg::ADR_CLEAR_FF)
                byte_ff_reg <= 1'b0;
            if (wr_ok && low_address_in == dma_pkg::ADR_COMMAND)
                command_reg <= data_in; // R15
            if (wr_ok && low_address_in == dma_pkg::ADR_REQUEST)
                request_reg[data_in[1:0]] <= data_in[2];
            if (wr_ok && low_address_in == dma_pkg::ADR_MASK_ONE)
                mask_reg[data_in[1:0]] <= data_in[2];
            if (wr_ok && low_address_in == dma_pkg::ADR_MASK_ALL)
                mask_reg <= data_in[3:0];
            if (rd_ok && low_address_in == dma_pkg::ADR_STATUS)
                status_tc_reg <= 4'h0;
            if (tc_event)
            begin
                status_tc_reg[chan_reg] <= 1'b1; // R15
                request_reg[chan_reg]   <= 1'b0;
                if (!mode_act.autoinit)
                    mask_reg[chan_reg] <= 1'b1;
            end
        end
    end

    always_comb
    begin
        read_byte = 8'h00;
        if (!low_address_in[3])
            read_byte = prog_word[byte_ff_reg*8 +: 8];
        else if (low_address_in == dma_pkg::ADR_STATUS)
            read_byte = {chan_active, status_tc_reg};
        else if (low_address_in == dma_pkg::ADR_TEMP)
            read_byte = temp_data_reg;
    end

    genvar g;
    generate
        for (g = 0; g < dma_pkg::CHANNELS; g++)
        begin : g_ack
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                    channel_acknowledge[g] <= dma_pkg::ACK_IDLE_LOW[g]; // R3
                else
                    channel_acknowledge[g] <= (own && chan_reg == g) ~^ ack_level; // R2
            end
        end
    endgenerate

    // Pins follow the state by one edge so each output leaves a flip-flop
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            bus_hold_request      <= 1'b0;
            upper_address_enable  <= 1'b0;
            upper_address_strobe  <= 1'b0;
            memory_read_strobe_n  <= 1'b1;
            memory_read_oe        <= 1'b0;
            memory_write_strobe_n <= 1'b1;
            memory_write_oe       <= 1'b0;
            low_address_out       <= 4'h0;
            low_address_oe        <= 1'b0;
            middle_address_lines  <= 4'h0;
            middle_address_oe     <= 1'b0;
            data_out              <= 8'h00;
            data_oe               <= 1'b0;
        end
        else
        begin
            bus_hold_request      <= (state_reg != dma_pkg::ST_IDLE); // R1
            upper_address_enable  <= drive; // R4
            upper_address_strobe  <= drive && state_reg == dma_pkg::ST_S1; // R6
            memory_read_oe        <= drive; // R16
            memory_write_oe       <= drive; // R16
            memory_read_strobe_n  <= !(drive && is_read && state_reg inside
                                       {dma_pkg::ST_S2, dma_pkg::ST_S3}); // R7
            memory_write_strobe_n <= !(drive && is_write && state_reg == dma_pkg::ST_S3); // R8
            low_address_out       <= cur_addr_reg[chan_reg][3:0];
            low_address_oe        <= drive; // R17
            middle_address_lines  <= cur_addr_reg[chan_reg][7:4];
            middle_address_oe     <= drive; // R18
            if (drive && state_reg == dma_pkg::ST_S1)
                data_out <= cur_addr_reg[chan_reg][15:8];
            else if (drive && mm_on)
                data_out <= temp_data_reg;
            else
                data_out <= read_byte;
            data_oe <= (drive && state_reg == dma_pkg::ST_S1) || rd_ok
                       || (drive && mm_on && chan_reg == 2'h1);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_strobe_pulse;
        upper_address_strobe ##1 !upper_address_strobe;
    endsequence
    sequence s_step;
        step_event && !tc_hit;
    endsequence

    a_hold_follows_request: assert property ( // R1
        (state_reg == dma_pkg::ST_IDLE && any_valid) |-> ##2 bus_hold_request)
        else $error("hold request missing after valid request");
    a_ack_granted_level: assert property ( // R2
        own |=> channel_acknowledge[$past(chan_reg)] == $past(ack_level))
        else $error("acknowledge level wrong during service");
    a_ack_idle_low: assert property ( // R3
        (!ack_level && !own) |=> channel_acknowledge == dma_pkg::ACK_IDLE_LOW)
        else $error("acknowledge not inactive high in low polarity");
    a_enable_with_strobe: assert property ( // R4
        upper_address_strobe |-> upper_address_enable && data_oe)
        else $error("strobe without address enable");
    a_strobe_one_cycle: assert property ( // R6
        $rose(upper_address_strobe) |-> s_strobe_pulse)
        else $error("upper address strobe longer than one cycle");
    a_read_strobe_driven: assert property ( // R7
        !memory_read_strobe_n |-> memory_read_oe && memory_write_strobe_n)
        else $error("memory read strobe undriven or overlaps write");
    a_write_strobe_driven: assert property ( // R8
        !memory_write_strobe_n |-> memory_write_oe && !upper_address_strobe)
        else $error("memory write strobe undriven");
    a_count_step_once: assert property ( // R10
        s_step |=> cur_count_reg[$past(chan_reg)] == $past(temp_count_reg) - dma_pkg::ONE16)
        else $error("current count did not step by one");
    a_winner_lowest: assert property ( // R12
        (state_reg == dma_pkg::ST_S0 && bus_hold_grant && !mm_on && valid[0]) |=> chan_reg == 2'h0)
        else $error("channel 0 lost priority");
    a_strobes_float: assert property ( // R16
        !bus_hold_grant |=> !memory_read_oe && !memory_write_oe)
        else $error("memory strobes driven without bus");
    a_middle_lines_service: assert property ( // R18
        middle_address_oe |-> $past(bus_hold_grant) && low_address_oe)
        else $error("middle address driven outside service");
    a_no_drive_ungranted: assert property ( // R19
        !bus_hold_grant |=> !upper_address_enable)
        else $error("bus driven without hold grant");
endmodule
`default_nettype wire

/* File: core/dma_pkg.sv */
/*
 Shared constants, types and the programming map of the four-channel DMA core.
 Assumes a single clock domain and synchronous programming strobes.
*/
package dma_pkg;
    localparam int CHANNELS = 4;

    typedef enum logic [2:0] {ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4} svc_state_t;

    typedef struct packed {
        logic [1:0] service;
        logic       decrement;
        logic       autoinit;
        logic [1:0] transfer;
    } mode_t;

    localparam logic [1:0] SVC_DEMAND   = 2'h0;
    localparam logic [1:0] SVC_SINGLE   = 2'h1;
    localparam logic [1:0] SVC_BLOCK    = 2'h2;
    localparam logic [1:0] SVC_CASCADE  = 2'h3;
    localparam logic [1:0] XFER_VERIFY  = 2'h0;
    localparam logic [1:0] XFER_WRITE   = 2'h1;
    localparam logic [1:0] XFER_READ    = 2'h2;

    localparam int CMD_MEM_TO_MEM = 0;
    localparam int CMD_DISABLE    = 2;
    localparam int CMD_REQ_LOW    = 6;
    localparam int CMD_ACK_HIGH   = 7;

    localparam logic [3:0] ADR_COMMAND      = 4'h8;
    localparam logic [3:0] ADR_STATUS       = 4'h8;
    localparam logic [3:0] ADR_REQUEST      = 4'h9;
    localparam logic [3:0] ADR_MASK_ONE     = 4'hA;
    localparam logic [3:0] ADR_MODE         = 4'hB;
    localparam logic [3:0] ADR_CLEAR_FF     = 4'hC;
    localparam logic [3:0] ADR_MASTER_CLEAR = 4'hD;
    localparam logic [3:0] ADR_TEMP         = 4'hD;
    localparam logic [3:0] ADR_MASK_ALL     = 4'hF;

    localparam logic [7:0]  COMMAND_RESET = 8'h00;
    localparam logic [3:0]  MASK_RESET    = 4'hF;
    localparam logic [3:0]  ACK_IDLE_LOW  = 4'hF;
    localparam logic [15:0] ONE16         = 16'h0001;
    localparam logic [15:0] LAST_COUNT    = 16'h0000;
endpackage

/* File: core/priority_pick.sv */
/*
 Fixed priority pick among four channel requests, channel 0 highest.
 Assumes a purely combinational use by the service core.
*/
`timescale 1ns/100ps
`default_nettype none
module priority_pick (
    input  wire logic [3:0] pending,
    output logic            found,
    output logic [1:0]      winner
);
    logic [4:0] blocked;
    logic [3:0] onehot;

    assign blocked[0] = 1'b0;
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_chain
            assign onehot[i]    = pending[i] & ~blocked[i];
            assign blocked[i+1] = blocked[i] | pending[i];
        end
    endgenerate

    assign found  = blocked[4];
    assign winner = {onehot[3] | onehot[2], onehot[3] | onehot[1]};
endmodule
`default_nettype wire

/* File: bench/processor_model.sv */
/*
 Processor side of the bus hold handshake for the DMA service core bench.
 Assumes lat is changed only while no hold request is pending.
*/
`timescale 1ns/100ps
`default_nettype none
module processor_model (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [3:0] lat,
    input  wire logic       bus_hold_request,
    output logic            bus_hold_grant
);
    logic [3:0] wait_reg;

    // Grant drops at the first edge after the request drops, so a slow bus release shows up
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            wait_reg       <= 4'h0;
            bus_hold_grant <= 1'b0;
        end
        else if (!bus_hold_request)
        begin
            wait_reg       <= 4'h0;
            bus_hold_grant <= 1'b0;
        end
        else if (wait_reg >= lat)
            bus_hold_grant <= 1'b1;
        else
            wait_reg <= wait_reg + 4'h1;
    end
endmodule
`default_nettype wire

/* File: bench/dma_service_core_bench.sv */
/*
 Bench for the DMA service core: a table of single transfers, then priority, masking,
 polarity and reset cases. Assumes the processor model answers hold requests.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_service_core_bench;
    typedef struct packed {
        logic [1:0]  ch;
        logic [1:0]  xfer;
        logic        dec;
        logic        auto;
        logic [3:0]  lat;
        logic [15:0] adr;
        logic [15:0] cnt;
        logic [15:0] exp_adr;
        logic [15:0] exp_cnt;
        logic        exp_rd;
        logic        exp_wr;
    } row_t;

    logic       ref_clk, reset, bus_hold_grant, ready, prog_select, prog_read, prog_write;
    logic [3:0] channel_request, low_address_in, lat, channel_acknowledge;
    logic [7:0] data_in, data_out, upper_seen, lower_seen;
    logic       bus_hold_request, upper_address_enable, upper_address_strobe;
    logic       memory_read_strobe_n, memory_read_oe, memory_write_strobe_n, memory_write_oe;
    logic [3:0] low_address_out, middle_address_lines, ack_seen;
    logic       low_address_oe, middle_address_oe, data_oe, rd_seen, wr_seen;
    logic [2:0] grant_hist;
    logic [15:0] v;
    int         miscompares, samples_checked;
    row_t       r;
    row_t       rows [5] = '{
        '{2'h0, dma_pkg::XFER_READ, 1'b0, 1'b0, 4'h0, 16'h5A3C, 16'h0005, 16'h5A3D, 16'h0004, 1'b1, 1'b0},
        '{2'h1, dma_pkg::XFER_WRITE, 1'b0, 1'b0, 4'h3, 16'h12F7, 16'h0100, 16'h12F8, 16'h00FF, 1'b0, 1'b1},
        '{2'h2, dma_pkg::XFER_VERIFY, 1'b0, 1'b0, 4'h1, 16'h80FF, 16'h0002, 16'h8100, 16'h0001, 1'b0, 1'b0},
        '{2'h3, dma_pkg::XFER_READ, 1'b1, 1'b0, 4'h2, 16'h4000, 16'h0001, 16'h3FFF, 16'h0000, 1'b1, 1'b0},
        '{2'h2, dma_pkg::XFER_WRITE, 1'b0, 1'b1, 4'h0, 16'h7770, 16'h0000, 16'h7770, 16'h0000, 1'b0, 1'b1}
    };

    dma_service_core DUT (
        .ref_clk(ref_clk), .reset(reset), .channel_request(channel_request),
        .bus_hold_grant(bus_hold_grant), .ready(ready), .prog_select(prog_select),
        .prog_read(prog_read), .prog_write(prog_write), .low_address_in(low_address_in),
        .data_in(data_in), .bus_hold_request(bus_hold_request),
        .channel_acknowledge(channel_acknowledge), .upper_address_enable(upper_address_enable),
        .upper_address_strobe(upper_address_strobe), .memory_read_strobe_n(memory_read_strobe_n),
        .memory_read_oe(memory_read_oe), .memory_write_strobe_n(memory_write_strobe_n),
        .memory_write_oe(memory_write_oe), .low_address_out(low_address_out),
        .low_address_oe(low_address_oe), .middle_address_lines(middle_address_lines),
        .middle_address_oe(middle_address_oe), .data_out(data_out), .data_oe(data_oe)
    );

    processor_model cpu (
        .ref_clk(ref_clk), .reset(reset), .lat(lat),
        .bus_hold_request(bus_hold_request), .bus_hold_grant(bus_hold_grant)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic prog(input logic rd, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        prog_select    <= 1'b1;
        prog_read      <= rd;
        prog_write     <= !rd;
        low_address_in <= a;
        data_in        <= d;
        @(posedge ref_clk);
        prog_select <= 1'b0;
        prog_read   <= 1'b0;
        prog_write  <= 1'b0;
        #1;
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] w);
        prog(1'b0, dma_pkg::ADR_CLEAR_FF, 8'h00);
        prog(1'b1, a, 8'h00);
        w[7:0] = data_out;
        prog(1'b1, a, 8'h00);
        w[15:8] = data_out;
    endtask

    // Waits are bounded so a stuck handshake ends as a mismatch, not a hang
    task automatic await_ack;
        for (int k = 0; k < 60 && channel_acknowledge === 4'hF; k++) @(posedge ref_clk);
    endtask

    task automatic settle;
        for (int k = 0; k < 60 && bus_hold_request !== 1'b0; k++) @(posedge ref_clk);
        for (int k = 0; k < 20 && bus_hold_grant !== 1'b0; k++) @(posedge ref_clk);
        check({15'h0, bus_hold_grant}, 16'h0000);
    endtask

    task automatic reset_check;
        @(posedge ref_clk);
        check({channel_acknowledge, bus_hold_request, upper_address_enable, upper_address_strobe,
               memory_read_strobe_n, memory_write_strobe_n, memory_read_oe, memory_write_oe,
               low_address_oe, middle_address_oe, data_oe, 2'b00}, 16'hF180);
    endtask

    always @(posedge ref_clk)
    begin
        grant_hist = {grant_hist[1:0], bus_hold_grant};
        if (upper_address_enable)
        begin
            ack_seen = channel_acknowledge;
            check({15'h0, bus_hold_grant}, 16'h0001);
        end
        if (upper_address_strobe)
        begin
            upper_seen = data_out;
            lower_seen = {middle_address_lines, low_address_out};
            check({14'h0, middle_address_oe, low_address_oe}, 16'h0003);
        end
        if (memory_read_oe && !memory_read_strobe_n)
            rd_seen = 1'b1;
        if (memory_write_oe && !memory_write_strobe_n)
            wr_seen = 1'b1;
        if (!reset && grant_hist === 3'b000)
            check({12'h0, memory_read_oe, memory_write_oe, middle_address_oe, low_address_oe},
                  16'h0000);
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        #(20000 * 10);
        miscompares++;
        tally_and_finish;
    end

    initial
    begin
        {reset, ready} = 2'b11;
        {prog_select, prog_read, prog_write, channel_request, low_address_in} = 11'h000;
        {data_in, lat, grant_hist} = 15'h0000;
        repeat (5) @(posedge ref_clk);
        reset_check;
        reset <= 1'b0;
        foreach (rows[i])
        begin
            r = rows[i];
            lat <= r.lat;
            prog(1'b0, dma_pkg::ADR_CLEAR_FF, 8'h00);
            prog(1'b0, {1'b0, r.ch, 1'b0}, r.adr[7:0]);
            prog(1'b0, {1'b0, r.ch, 1'b0}, r.adr[15:8]);
            prog(1'b0, {1'b0, r.ch, 1'b1}, r.cnt[7:0]);
            prog(1'b0, {1'b0, r.ch, 1'b1}, r.cnt[15:8]);
            prog(1'b0, dma_pkg::ADR_MODE, {dma_pkg::SVC_SINGLE, r.dec, r.auto, r.xfer, r.ch});
            prog(1'b0, dma_pkg::ADR_MASK_ONE, {6'h00, r.ch});
            {rd_seen, wr_seen, ack_seen} = 6'h0F;
            @(posedge ref_clk);
            channel_request[r.ch] <= 1'b1;
            await_ack;
            channel_request[r.ch] <= 1'b0;
            settle;
            check({12'h0, ack_seen}, {12'h0, ~(4'h1 << r.ch)});
            check({upper_seen, lower_seen}, r.adr);
            check({14'h0, rd_seen, wr_seen}, {14'h0, r.exp_rd, r.exp_wr});
            rd16({1'b0, r.ch, 1'b0}, v);
            check(v, r.exp_adr);
            rd16({1'b0, r.ch, 1'b1}, v);
            check(v, r.exp_cnt);
        end
        // Only the autoinit row reached count end, on channel 2
        prog(1'b1, dma_pkg::ADR_STATUS, 8'h00);
        check({12'h0, data_out[3:0]}, 16'h0004);
        ack_seen = 4'hF;
        @(posedge ref_clk);
        channel_request <= 4'h6;
        ready           <= 1'b0;
        await_ack;
        channel_request <= 4'h0;
        // With ready low the write must sit in its wait state
        repeat (6) @(posedge ref_clk);
        check({15'h0, memory_write_strobe_n}, 16'h0000);
        ready <= 1'b1;
        settle;
        check({12'h0, ack_seen}, 16'h000D);
        prog(1'b0, dma_pkg::ADR_MASK_ALL, 8'h0F);
        @(posedge ref_clk);
        channel_request <= 4'hF;
        repeat (8) @(posedge ref_clk) check({15'h0, bus_hold_request}, 16'h0000);
        channel_request <= 4'h0;
        prog(1'b0, dma_pkg::ADR_COMMAND, 8'h80);
        repeat (3) @(posedge ref_clk);
        check({12'h0, channel_acknowledge}, 16'h0000);
        reset <= 1'b1;
        reset_check;
        reset <= 1'b0;
        tally_and_finish;
    end
endmodule
`default_nettype wire
